// File: rtl/acq_seq_pkg.sv
package acq_seq_pkg;
  localparam int COUNT_W = 24;
  localparam int CHAN_N = 8;
  // Register word offsets (byte addresses)
  localparam logic [5:0] OFS_CONTROL = 6'h00;
  localparam logic [5:0] OFS_PRE_COUNT = 6'h04;
  localparam logic [5:0] OFS_POST_COUNT = 6'h08;
  localparam logic [5:0] OFS_DELAY = 6'h0c;
  localparam logic [5:0] OFS_DIVIDER = 6'h10;
  localparam logic [5:0] OFS_STATUS = 6'h14;
  localparam logic [5:0] OFS_COUNT = 6'h18;
  localparam logic [5:0] OFS_COMMAND = 6'h1c;
  // Control fields
  localparam int CTL_PRETRIG = 0;
  localparam int CTL_SW_START = 1;
  localparam int CTL_INT_STROBE = 2;
  localparam int CTL_FILT_LO = 4;
  localparam int CTL_FILT_W = 4;
  localparam int CTL_W = 8;
  // Command fields
  localparam int CMD_START = 0;
  localparam int CMD_ABORT = 1;
  // Status fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_PRE_MET = 2;
  localparam int ST_PHASE_LO = 4;
  // Reset values
  localparam logic [CTL_W-1:0] CONTROL_RESET = 8'h00;
  localparam logic [COUNT_W-1:0] PRE_RESET = 24'h000004;
  localparam logic [COUNT_W-1:0] POST_RESET = 24'h000005;
  localparam logic [15:0] DELAY_RESET = 16'h0002;
  localparam logic [15:0] DIVIDER_RESET = 16'h0063;
  // Digital filter: an input must hold stable for this many nanoseconds
  localparam int FILTER_TIME_NS = 16;
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int FILTER_CYCLES = (FILTER_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
endpackage : acq_seq_pkg

// File: rtl/acq_trigger_sample_sequencer.sv
// How it works
// - One strobe samples all active channels together
// - Posttrigger only: load post count, decrement
// - Software start emits a start trigger pulse
// - Pretrigger: start loads pre count, later post
// - Early reference trigger ignored, keep acquiring
// - Accepted reference starts posttrigger countdown, completes
// - Optional filters on strobe and three triggers
// - Strobes ignored when idle or on hold
// - Internal strobe after delay, default two ticks
// - Reference acquisition never re-arms after finishing
module acq_trigger_sample_sequencer
  import acq_seq_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic EXT_SAMPLE_STROBE,
  input wire logic ACQ_BEGIN_TRIGGER_IN,
  input wire logic REF_EVENT_TRIGGER,
  input wire logic HOLD_OFF_TRIGGER,
  input wire logic STROBE_TIMEBASE,
  output logic ACQ_BEGIN_TRIGGER_OUT,
  output logic [CHAN_N-1:0] CHANNEL_SAMPLE,
  output logic SAMPLE_STROBE_OUT,
  output logic ACQ_DONE
);
  typedef enum logic [1:0] {IDLE = 2'b00, PRE = 2'b01, WAIT_REF = 2'b11, POST = 2'b10} phase_t;
  typedef struct packed {
    logic [1:0] sy_strobe, sy_begin, sy_ref, sy_hold, sy_tb;
    logic [CTL_FILT_W-1:0][2:0] filt_cnt;
    logic [CTL_FILT_W-1:0] filt_out;
    logic tb_prev, strobe_prev, begin_prev, ref_prev;
    logic [CTL_W-1:0] control;
    logic [COUNT_W-1:0] pre_count, post_count, count;
    logic [15:0] delay, divider, tick_cnt;
    logic delay_run;
    logic [CHAN_N-1:0] chan_en;
    phase_t phase;
    logic pre_met, done, begin_pulse;
    logic [CHAN_N-1:0] sample;
    logic strobe_out, ack;
    logic [31:0] rdata;
  } state_t;
  state_t s, next_s;
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
    return r;
  endfunction : merge
  function automatic logic rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction : rise
  //////////////////////////////////////////////////////////////////////////////
  logic [CTL_FILT_W-1:0] raw_in;
  logic strobe_lvl, begin_lvl, ref_lvl, hold_lvl;
  logic tb_tick, int_strobe, strobe_edge, begin_edge, ref_edge, sw_start, abort, wr, rd;
  logic [31:0] wmerged;
  always_comb
  begin
    next_s = s;
    // Only the second stage feeds logic
    next_s.sy_strobe = {s.sy_strobe[0], EXT_SAMPLE_STROBE};
    next_s.sy_begin = {s.sy_begin[0], ACQ_BEGIN_TRIGGER_IN};
    next_s.sy_ref = {s.sy_ref[0], REF_EVENT_TRIGGER};
    next_s.sy_hold = {s.sy_hold[0], HOLD_OFF_TRIGGER};
    next_s.sy_tb = {s.sy_tb[0], STROBE_TIMEBASE};
    raw_in = {s.sy_hold[1], s.sy_ref[1], s.sy_begin[1], s.sy_strobe[1]};
    // Filter: output follows input only after it has held steady
    for (int i = 0; i < CTL_FILT_W; i++)
    begin
      if (raw_in[i] == s.filt_out[i])
        next_s.filt_cnt[i] = '0;
      else if (s.filt_cnt[i] == 3'(FILTER_CYCLES - 1))
      begin
        next_s.filt_out[i] = raw_in[i];
        next_s.filt_cnt[i] = '0;
      end
      else
        next_s.filt_cnt[i] = s.filt_cnt[i] + 3'd1;
    end
    // Timebase has no filter
    strobe_lvl = s.control[CTL_FILT_LO] ? s.filt_out[0] : raw_in[0];
    begin_lvl = s.control[CTL_FILT_LO + 1] ? s.filt_out[1] : raw_in[1];
    ref_lvl = s.control[CTL_FILT_LO + 2] ? s.filt_out[2] : raw_in[2];
    hold_lvl = s.control[CTL_FILT_LO + 3] ? s.filt_out[3] : raw_in[3];
    next_s.tb_prev = s.sy_tb[1];
    next_s.strobe_prev = strobe_lvl;
    next_s.begin_prev = begin_lvl;
    next_s.ref_prev = ref_lvl;
    tb_tick = rise(s.sy_tb[1], s.tb_prev);
    begin_edge = rise(begin_lvl, s.begin_prev);
    ref_edge = rise(ref_lvl, s.ref_prev);
    // Bus
    // Writes land at the edge after the one that ends the wait state
    wr = AVS_WRITE & s.ack;
    rd = AVS_READ & ~s.ack;
    next_s.ack = (AVS_WRITE | AVS_READ) & ~s.ack;
    wmerged = '0;
    sw_start = 1'b0;
    abort = 1'b0;
    if (wr)
    begin
      unique case (AVS_ADDRESS)
        OFS_CONTROL: next_s.control = CTL_W'(merge({24'h0, s.control}, AVS_WRITEDATA,
                                                   AVS_BYTEENABLE));
        OFS_PRE_COUNT: next_s.pre_count = COUNT_W'(merge({8'h0, s.pre_count}, AVS_WRITEDATA,
                                                         AVS_BYTEENABLE));
        OFS_POST_COUNT: next_s.post_count = COUNT_W'(merge({8'h0, s.post_count}, AVS_WRITEDATA,
                                                           AVS_BYTEENABLE));
        OFS_DELAY: next_s.delay = 16'(merge({16'h0, s.delay}, AVS_WRITEDATA, AVS_BYTEENABLE));
        OFS_DIVIDER:
        begin
          wmerged = merge({s.chan_en, 8'h0, s.divider}, AVS_WRITEDATA, AVS_BYTEENABLE);
          next_s.divider = wmerged[15:0];
          next_s.chan_en = wmerged[31:24];
        end
        OFS_COMMAND:
        begin
          sw_start = AVS_BYTEENABLE[0] & AVS_WRITEDATA[CMD_START];
          abort = AVS_BYTEENABLE[0] & AVS_WRITEDATA[CMD_ABORT];
        end
        default: ;
      endcase
    end
    // Internal timing engine: divider ticks on the timebase
    int_strobe = 1'b0;
    if (s.phase == IDLE)
    begin
      next_s.tick_cnt = '0;
      next_s.delay_run = 1'b0;
    end
    else if (tb_tick)
    begin
      if (s.tick_cnt == (s.delay_run ? s.delay - 16'd1 : s.divider))
      begin
        next_s.tick_cnt = '0;
        next_s.delay_run = 1'b0;
        int_strobe = 1'b1;
      end
      else
        next_s.tick_cnt = s.tick_cnt + 16'd1;
    end
    next_s.strobe_out = 1'b0;
    next_s.sample = '0;
    next_s.begin_pulse = 1'b0;
    strobe_edge = s.control[CTL_INT_STROBE] ? int_strobe : rise(strobe_lvl, s.strobe_prev);
    // Start: a software start pulses the trigger line
    if (s.phase == IDLE && (s.control[CTL_SW_START] ? sw_start : begin_edge))
    begin
      next_s.begin_pulse = s.control[CTL_SW_START];
      next_s.done = 1'b0;
      next_s.pre_met = 1'b0;
      next_s.tick_cnt = '0;
      next_s.delay_run = 1'b1;
      if (s.control[CTL_PRETRIG])
      begin
        next_s.phase = (s.pre_count == '0) ? WAIT_REF : PRE;
        next_s.count = s.pre_count;
        next_s.pre_met = s.pre_count == '0;
      end
      else
      begin
        next_s.phase = POST;
        next_s.count = s.post_count;
      end
    end
    else if (s.phase != IDLE && strobe_edge && !hold_lvl)
    begin
      next_s.sample = s.chan_en;
      next_s.strobe_out = 1'b1;
      if (s.count != '0)
        next_s.count = s.count - COUNT_W'(1);
      if (s.phase == PRE && s.count == COUNT_W'(1))
      begin
        next_s.pre_met = 1'b1;
        next_s.phase = WAIT_REF;
      end
      if (s.phase == POST && s.count == COUNT_W'(1))
      begin
        next_s.phase = IDLE;
        next_s.done = 1'b1;
      end
    end
    // Pretrigger samples keep flowing; reference only counts once met
    if ((s.phase == PRE || s.phase == WAIT_REF) && ref_edge && next_s.pre_met)
    begin
      next_s.phase = POST;
      next_s.count = s.post_count;
    end
    if (s.phase == POST && s.post_count == '0 && s.count == '0)
    begin
      next_s.phase = IDLE;
      next_s.done = 1'b1;
    end
    // Abort last so it beats any phase change in the same cycle
    if (abort)
      next_s.phase = IDLE;
    next_s.rdata = s.rdata;
    if (rd)
    begin
      unique case (AVS_ADDRESS)
        OFS_CONTROL: next_s.rdata = {24'h0, s.control};
        OFS_PRE_COUNT: next_s.rdata = {8'h0, s.pre_count};
        OFS_POST_COUNT: next_s.rdata = {8'h0, s.post_count};
        OFS_DELAY: next_s.rdata = {16'h0, s.delay};
        OFS_DIVIDER: next_s.rdata = {s.chan_en, 8'h0, s.divider};
        OFS_STATUS: next_s.rdata = {26'h0, s.phase, 1'b0, s.pre_met, s.done, s.phase != IDLE};
        OFS_COUNT: next_s.rdata = {8'h0, s.count};
        default: next_s.rdata = UNMAPPED_READ;
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s <= '0;
      s.control <= CONTROL_RESET;
      s.pre_count <= PRE_RESET;
      s.post_count <= POST_RESET;
      s.delay <= DELAY_RESET;
      s.divider <= DIVIDER_RESET;
      s.chan_en <= '1;
      s.phase <= IDLE;
    end
    else
      s <= next_s;
  end
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~s.ack;
  assign AVS_READDATA = s.rdata;
  assign ACQ_BEGIN_TRIGGER_OUT = s.begin_pulse;
  assign CHANNEL_SAMPLE = s.sample;
  assign SAMPLE_STROBE_OUT = s.strobe_out;
  assign ACQ_DONE = s.done;
  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  sequence seq_waiting_ref;
    s.phase == PRE || s.phase == WAIT_REF;
  endsequence
  sequence seq_ref_taken;
    seq_waiting_ref ##1 s.phase == POST;
  endsequence
  a_all_channels_together: assert property (SAMPLE_STROBE_OUT
    |-> CHANNEL_SAMPLE == $past(s.chan_en))
    else $error("strobe did not sample all enabled channels");
  a_post_load_count: assert property ($rose(s.phase == POST) && $past(s.phase) == IDLE
    |-> s.count == $past(s.post_count))
    else $error("post count not loaded at start");
  a_sw_start_pulse: assert property (ACQ_BEGIN_TRIGGER_OUT
    |-> $past(s.control[CTL_SW_START]) && s.phase != IDLE)
    else $error("start pulse without software start");
  a_pre_load_count: assert property ($past(s.phase) == IDLE && s.phase == PRE
    |-> s.count == $past(s.pre_count))
    else $error("pre count not loaded at start");
  a_early_ref_ignored: assert property (s.phase == PRE && ref_edge && !next_s.pre_met
    |=> s.phase != POST)
    else $error("early reference accepted");
  a_ref_to_post: assert property (seq_ref_taken |-> s.count == $past(s.post_count))
    else $error("posttrigger count not reloaded");
  a_strobe_idle_gated: assert property (s.phase == IDLE |=> !SAMPLE_STROBE_OUT)
    else $error("strobe passed while idle");
  a_strobe_hold_gated: assert property (hold_lvl |=> !SAMPLE_STROBE_OUT)
    else $error("strobe passed while on hold");
  a_no_rearm: assert property (s.phase == IDLE && ref_edge && !sw_start && !begin_edge
    |=> s.phase == IDLE)
    else $error("acquisition re-armed by reference trigger");
  a_done_on_zero: assert property ($rose(ACQ_DONE) |-> s.phase == IDLE && s.count == '0)
    else $error("done without exhausted count");
endmodule : acq_trigger_sample_sequencer

// File: verif/tb.sv
module tb
  import acq_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] addr;
  logic rd, wr, wait_req;
  logic [31:0] wdata, rdata, q;
  logic strobe, begin_in, ref_trig, hold, tbase, begin_out, smp, done;
  logic [CHAN_N-1:0] chans;
  logic [7:0] lfsr = 8'h1a;
  logic [7:0] mask = 8'hff;
  logic [3:0] be = 4'hf;
  logic [23:0] post;
  int mismatches = 0;
  int num_checks = 0;
  int pulses = 0;
  int starts = 0;
  always #2 clock = ~clock;
  acq_trigger_sample_sequencer u_acq_trigger_sample_sequencer (.CLOCK(clock), .RST_N(rst_n),
    .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
    .EXT_SAMPLE_STROBE(strobe), .ACQ_BEGIN_TRIGGER_IN(begin_in), .REF_EVENT_TRIGGER(ref_trig),
    .HOLD_OFF_TRIGGER(hold), .STROBE_TIMEBASE(tbase), .ACQ_BEGIN_TRIGGER_OUT(begin_out),
    .CHANNEL_SAMPLE(chans), .SAMPLE_STROBE_OUT(smp), .ACQ_DONE(done));
  trig_source u_trig_source (.clock(clock), .strobe(strobe), .begin_trig(begin_in),
    .ref_trig(ref_trig), .hold(hold), .tbase(tbase));
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : rnd
  function automatic logic [31:0] status(input logic [1:0] ph, input logic pm, input logic dn);
    logic [31:0] r;
    r = '0;
    r[ST_PHASE_LO +: 2] = ph;
    r[ST_PRE_MET] = pm;
    r[ST_DONE] = dn;
    r[ST_BUSY] = ph != 2'b00;
    return r;
  endfunction : status
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  always @(posedge clock)
  begin
    if (smp === 1'b1)
    begin
      pulses++;
      chk(32'(chans), 32'(mask));
    end
    if (begin_out === 1'b1)
      starts++;
  end
  // Request held until waitrequest is sampled low at a rising edge; one idle edge after
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    do
      @(posedge clock);
    while (wait_req !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd_chk
  task automatic strobes(input int n);
    repeat (n) u_trig_source.pulse(0, 6);
  endtask : strobes
  task automatic final_report();
    if (mismatches == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    final_report();
  end
  initial
  begin
    {addr, rd, wr, wdata} = '0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd_chk(OFS_PRE_COUNT, 32'(PRE_RESET));
    rd_chk(OFS_POST_COUNT, 32'(POST_RESET));
    rd_chk(OFS_DELAY, 32'(DELAY_RESET));
    rd_chk(6'h3c, UNMAPPED_READ);
    // Software start, strobe filter on, random mask and length
    mask = rnd();
    post = 24'(rnd() & 8'h03) + 24'h1;
    bus(1'b1, OFS_DIVIDER, {mask, 8'h00, DIVIDER_RESET});
    bus(1'b1, OFS_CONTROL, 32'h12);
    bus(1'b1, OFS_POST_COUNT, 32'(post));
    strobes(2);
    chk(pulses, 0);
    bus(1'b1, OFS_COMMAND, 32'h1);
    repeat (6) @(posedge clock);
    chk(starts, 1);
    u_trig_source.pulse(0, 2);
    chk(pulses, 0);
    u_trig_source.set(4, 1'b1);
    repeat (8) @(posedge clock);
    strobes(1);
    u_trig_source.set(4, 1'b0);
    repeat (8) @(posedge clock);
    chk(pulses, 0);
    strobes(32'(post));
    chk(pulses, 32'(post));
    chk(done, 1);
    rd_chk(OFS_STATUS, status(2'b00, 1'b0, 1'b1));
    strobes(1);
    chk(pulses, 32'(post));
    // Hardware start with pretrigger and an early reference
    pulses = 0;
    bus(1'b1, OFS_CONTROL, 32'h1);
    bus(1'b1, OFS_PRE_COUNT, 32'h2);
    bus(1'b1, OFS_POST_COUNT, 32'h3);
    u_trig_source.pulse(1, 6);
    chk(done, 0);
    chk(starts, 1);
    strobes(1);
    u_trig_source.pulse(2, 6);
    strobes(2);
    rd_chk(OFS_STATUS, status(2'b11, 1'b1, 1'b0));
    rd_chk(OFS_COUNT, 32'h0);
    u_trig_source.pulse(2, 6);
    strobes(2);
    rd_chk(OFS_COUNT, 32'h1);
    chk(done, 0);
    strobes(1);
    chk(done, 1);
    chk(pulses, 6);
    u_trig_source.pulse(2, 6);
    strobes(1);
    chk(pulses, 6);
    // Internal strobe: one timebase tick per period, default delay
    pulses = 0;
    bus(1'b1, OFS_DIVIDER, {mask, 24'h0});
    bus(1'b1, OFS_CONTROL, 32'h6);
    bus(1'b1, OFS_POST_COUNT, 32'h2);
    bus(1'b1, OFS_COMMAND, 32'h1);
    u_trig_source.pulse(3, 6);
    chk(pulses, 0);
    repeat (6) u_trig_source.pulse(3, 6);
    chk(pulses, 2);
    chk(done, 1);
    // Abort mid-acquisition, then a one-lane write
    pulses = 0;
    bus(1'b1, OFS_CONTROL, 32'h2);
    bus(1'b1, OFS_COMMAND, 32'h1);
    rd_chk(OFS_STATUS, status(2'b10, 1'b0, 1'b0));
    bus(1'b1, OFS_COMMAND, 32'h2);
    rd_chk(OFS_STATUS, status(2'b00, 1'b0, 1'b0));
    strobes(1);
    chk(pulses, 0);
    chk(starts, 3);
    be <= 4'h1;
    bus(1'b1, OFS_PRE_COUNT, 32'h00aabb07);
    be <= 4'hf;
    rd_chk(OFS_PRE_COUNT, 32'h7);
    final_report();
  end
endmodule : tb

// File: verif/trig_source.sv
module trig_source (
  input wire logic clock,
  output logic strobe,
  output logic begin_trig,
  output logic ref_trig,
  output logic hold,
  output logic tbase
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {strobe, begin_trig, ref_trig, hold, tbase} = 5'h00;
  end
  // 0 strobe, 1 start, 2 reference, 3 timebase, else hold level
  task automatic set(input int sel, input logic v);
    case (sel)
      0: strobe <= v;
      1: begin_trig <= v;
      2: ref_trig <= v;
      3: tbase <= v;
      default: hold <= v;
    endcase
  endtask : set
  // Low tail long enough for sync and filter to settle
  task automatic pulse(input int sel, input int w);
    set(sel, 1'b1);
    repeat (w) @(posedge clock);
    set(sel, 1'b0);
    repeat (6) @(posedge clock);
  endtask : pulse
endmodule : trig_source
